// ### core/adc_ctrl_defs.svh
// Offsets, field positions, reset values and timing counts of the converter control block.
// Included by the control module, the checker and the bench; definitions only.
`ifndef ADC_CTRL_DEFS_SVH
`define ADC_CTRL_DEFS_SVH
`define OFS_CONTROL      12'h000
`define OFS_TRIGGER      12'h004
`define OFS_RANGE        12'h008
`define OFS_FLAGS        12'h00C
`define OFS_ENABLES      12'h010
`define OFS_RESULT_BASE  12'h020
`define RES_INPUTS       8
`define RES_WIDTH        12
`define TRG_RESET        16'h0007
`define SAMPLE_BASE      4
`define CONVERT_CYCLES   14
`define TIMER_DIV        4
`define FLD_START        1
`define FLD_BUSY         10
`define FLD_CUR_LO       12
`define FLD_SAMPLE_LO    0
`define FLD_TRIG_LO      4
`define FLD_SCAN         6
`define FLD_ALIGN        7
`define FLD_FIRST_LO     8
`define FLD_LAST_LO      11
`endif

// ### core/adc_ctrl_pkg.sv
// Types shared by the converter control block.
// Needs no include; the trig_cfg_t layout matches the field positions of the defs header.
package adc_ctrl_pkg;
  typedef enum logic [1:0] {
    trig_soft  = 2'h0,
    trig_timer = 2'h1,
    trig_rsvd  = 2'h2,
    trig_pin   = 2'h3
  } trig_src_t;
  typedef struct packed {
    logic [1:0] reserved_hi;
    logic [2:0] last_input_select;
    logic [2:0] first_input_select;
    logic       align_select;
    logic       scan_mode_select;
    trig_src_t  trigger_source_select;
    logic       reserved_lo;
    logic [2:0] sampling_time_select;
  } trig_cfg_t;
  typedef struct packed {
    logic        valid;
    logic [2:0]  input_num;
    logic [11:0] value;
  } conv_result_t;
endpackage

// ### core/adc_trigger_result_control.sv
// Converter control block: APB registers, trigger, scan sequencer, results, interrupts.
// Assumes a converter core that returns one 12-bit value per conversion request.
// Summary of operation
// - Alignment bit 1 shows results left justified, 0 right, on every result at once.
// - A 12-bit value sits in the upper or lower twelve bits of its 16-bit word, rest zero.
// - Scan mode 1 repeats the input range continuously, 0 scans it once and stops.
// - Trigger code 3 is the pin, 1 the timer underflow, 0 the software start, 2 reserved.
// - Sampling code 0 to 7 gives 4 to 11 timer-clock cycles of sampling.
// - Range code 0 blocks every trigger and every scan repeat; a scan under way still finishes its range.
// - Flags hold overwrite errors in bits 15-8 and completions in 7-0, cleared by writing 1.
// - Enables mirror the flag layout, a one enables, and all reset to zero.
// - Each input has a read-only result word that resets to zero.
// - Loading a new result sets that input's completion flag.
// - Loading a result while completion is still set sets the overwrite flag; scanning goes on.
// - The interrupt is raised only while a set flag has its enable at one.
// - A scan converts inputs from first to last in ascending order.
//
// The implementer's own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`include "adc_ctrl_defs.svh"
module adc_trigger_result_control #(
  parameter int INPUTS = `RES_INPUTS
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Trigger sources
  input  wire logic        timer_underflow,
  input  wire logic        external_trigger_pin_n,
  // Converter core
  output logic             conv_start,
  output logic [2:0]       conv_input,
  output logic [1:0]       conv_range,
  input  wire logic        conv_done,
  input  wire logic [11:0] conv_value,
  // Interrupt
  output logic             irq
);
  import adc_ctrl_pkg::*;
  initial if (INPUTS != 8) $error("INPUTS must be 8");

  typedef enum logic [2:0] {st_idle, st_wait_tick, st_sample, st_convert, st_next} seq_t;

  trig_cfg_t        trig_r;
  logic [1:0]       range_r;
  logic [15:0]      flags_r;
  logic [15:0]      enables_r;
  logic             start_r;
  logic             busy_status_r;
  logic [2:0]       cur_r;
  logic [3:0]       cnt_r;
  logic [11:0]      raw_r [INPUTS];
  logic [15:0]      aligned [INPUTS];
  logic             armed_r;
  logic             pin_prev_r;
  logic             timer_tick_en;
  seq_t             state_r;
  conv_result_t     res;
  logic             wr_en;
  logic             rd_en;
  logic [15:0]      load_mask;
  logic [15:0]      flags_nxt;
  logic             trig_hit;
  logic             mapped;
  logic [31:0]      rdata_nxt;

  timer_tick #(
    .DIV (`TIMER_DIV)
  ) u_tick (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (timer_tick_en)
  );

  for (genvar g = 0; g < INPUTS; g++)
  begin : g_align
    result_align u_align (
      .align_select (trig_r.align_select),
      .raw          (raw_r[g]),
      .aligned      (aligned[g])
    );
  end

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !pwrite;

  // Register writes; trigger setup taken at any time, busy or idle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      trig_r    <= trig_cfg_t'(`TRG_RESET);
      range_r   <= 2'h0;
      start_r   <= 1'b0;
    end
    else if (wr_en)
    begin
      unique case (paddr)
        `OFS_CONTROL: start_r <= pwdata[`FLD_START];
        `OFS_TRIGGER:
        begin
          trig_r             <= trig_cfg_t'(pwdata[15:0]);
          trig_r.reserved_hi <= 2'h0;
          trig_r.reserved_lo <= 1'b0;
        end
        `OFS_RANGE: range_r <= pwdata[1:0];
        default: ;
      endcase
    end
  end

  // Interrupt enables; plain read-write word
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      enables_r <= 16'h0000;
    else if (wr_en && paddr == `OFS_ENABLES)
      enables_r <= pwdata[15:0];
  end

  // Pin history resets high, its idle level, so reset gives no false edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pin_prev_r <= 1'b1;
    else
      pin_prev_r <= external_trigger_pin_n;
  end

  // Soft start fires once per rise of start; a new scan needs start cleared first
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      armed_r <= 1'b0;
    else if (!start_r)
      armed_r <= 1'b0;
    else if (trig_hit)
      armed_r <= 1'b1;
  end

  always_comb
  begin
    trig_hit = 1'b0;
    if (start_r && !busy_status_r && range_r != 2'h0)
    begin
      unique case (trig_r.trigger_source_select)
        trig_soft:  trig_hit = !armed_r;
        trig_timer: trig_hit = timer_underflow;
        trig_pin:   trig_hit = pin_prev_r && !external_trigger_pin_n;
        default:    trig_hit = 1'b0;
      endcase
    end
  end

  // Scan sequencer, paced by the timer-clock enable
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r       <= st_idle;
      busy_status_r <= 1'b0;
      cur_r         <= 3'h0;
      cnt_r         <= 4'h0;
      conv_start    <= 1'b0;
      conv_input    <= 3'h0;
    end
    else
    begin
      conv_start <= 1'b0;
      unique case (state_r)
        st_idle:
          if (trig_hit)
          begin
            busy_status_r <= 1'b1;
            cur_r         <= trig_r.first_input_select;
            state_r       <= st_wait_tick;
          end
        st_wait_tick:
          if (timer_tick_en)
          begin
            cnt_r   <= 4'(`SAMPLE_BASE) + {1'b0, trig_r.sampling_time_select};
            state_r <= st_sample;
          end
        st_sample:
          if (timer_tick_en)
          begin
            if (cnt_r == 4'h1)
            begin
              conv_start <= 1'b1;
              conv_input <= cur_r;
              state_r    <= st_convert;
            end
            cnt_r <= cnt_r - 4'h1;
          end
        st_convert:
          if (conv_done)
            state_r <= st_next;
        st_next:
          if (cur_r < trig_r.last_input_select)
          begin
            cur_r   <= cur_r + 3'h1;
            state_r <= st_wait_tick;
          end
          else if (trig_r.scan_mode_select && start_r && range_r != 2'h0)
          begin
            cur_r   <= trig_r.first_input_select;
            state_r <= st_wait_tick;
          end
          else
          begin
            busy_status_r <= 1'b0;
            state_r       <= st_idle;
          end
        default: state_r <= st_idle;
      endcase
      // Stop honoured only between conversions, never mid-conversion
      if (state_r == st_wait_tick && !start_r)
      begin
        busy_status_r <= 1'b0;
        state_r       <= st_idle;
      end
    end
  end

  assign res = '{valid: (state_r == st_convert) && conv_done, input_num: cur_r,
                 value: conv_value};

  // Raw result storage; alignment stays on the read path
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < INPUTS; i++)
        raw_r[i] <= 12'h000;
    end
    else if (res.valid)
      raw_r[res.input_num] <= res.value;
  end

  // Flags: a hardware set wins over a same-cycle software clear
  always_comb
  begin
    load_mask = 16'h0000;
    if (res.valid)
    begin
      load_mask[res.input_num] = 1'b1;
      load_mask[8 + res.input_num] = flags_r[res.input_num];
    end
    flags_nxt = flags_r;
    if (wr_en && paddr == `OFS_FLAGS)
      flags_nxt = flags_r & ~pwdata[15:0];
    flags_nxt = flags_nxt | load_mask;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      flags_r <= 16'h0000;
    else
      flags_r <= flags_nxt;
  end

  // Taken from the next flags so irq rises on the same edge as the flag
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq <= 1'b0;
    else
      irq <= |(flags_nxt & enables_r);
  end

  // Read decode; unmapped addresses answer with an error
  always_comb
  begin
    rdata_nxt = 32'h0000_0000;
    mapped    = 1'b1;
    unique case (paddr)
      `OFS_CONTROL:
      begin
        rdata_nxt[`FLD_START] = start_r;
        rdata_nxt[`FLD_BUSY]  = busy_status_r;
        rdata_nxt[`FLD_CUR_LO +: 3] = cur_r;
      end
      `OFS_TRIGGER: rdata_nxt[15:0] = trig_r;
      `OFS_RANGE:   rdata_nxt[1:0] = range_r;
      `OFS_FLAGS:   rdata_nxt[15:0] = flags_r;
      `OFS_ENABLES: rdata_nxt[15:0] = enables_r;
      default:
        if (paddr >= `OFS_RESULT_BASE && paddr < 12'(`OFS_RESULT_BASE + 4 * INPUTS)
            && paddr[1:0] == 2'h0)
          rdata_nxt[15:0] = aligned[paddr[4:2]];
        else
          mapped = 1'b0;
    endcase
  end

  // Answer one cycle after setup: pready high in the first access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pready <= 1'b0;
    else
      pready <= psel && !penable;
  end

  // Unmapped address answers with an error; a write there changes nothing
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pslverr <= 1'b0;
    else
      pslverr <= psel && !penable && !mapped;
  end

  // Read data only in the access cycle, zero otherwise to keep the bus quiet
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else
      prdata <= (rd_en && !penable) ? rdata_nxt : 32'h0000_0000;
  end

  // Registered copy so the core sees a settled range code
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      conv_range <= 2'h0;
    else
      conv_range <= range_r;
  end
endmodule // adc_trigger_result_control

// ### core/result_align.sv
// Read-path alignment of a raw 12-bit result into 16 bits.
// Pure combinational; raw value is never altered.
`timescale 1ns/1ps
module result_align (
  // Control
  input  wire logic        align_select,
  // Data
  input  wire logic [11:0] raw,
  output logic [15:0]      aligned
);
  assign aligned = align_select ? {raw, 4'h0} : {4'h0, raw};
endmodule // result_align

// ### core/timer_tick.sv
// Divider producing a one-cycle timer-clock enable from pclk.
// Assumes a single synchronous pclk domain.
`timescale 1ns/1ps
module timer_tick #(
  parameter int DIV = 4
) (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Enable
  output logic      tick
);
  initial if (DIV < 2) $error("DIV must be at least 2");
  logic [$clog2(DIV)-1:0] cnt_r;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_r <= '0;
      tick  <= 1'b0;
    end
    else
    begin
      tick  <= (cnt_r == $bits(cnt_r)'(DIV - 1));
      cnt_r <= (cnt_r == $bits(cnt_r)'(DIV - 1)) ? '0 : cnt_r + 1'b1;
    end
  end
endmodule // timer_tick

// ### testbench/adc_ctrl_properties.sv
// Port-level checks of the converter control block.
// Assumes pclk with asynchronous active-low presetn; bound from the bench.
`timescale 1ns/1ps
`include "adc_ctrl_defs.svh"
module adc_ctrl_properties (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Core and interrupt
  input wire logic        conv_start,
  input wire logic [1:0]  conv_range,
  input wire logic        irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_ready_setup;
    psel && !penable |=> pready;
  endproperty
  a_ready_setup: assert property (p_ready_setup)
    else $error("pready missing after setup");
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("pready longer than one cycle");
  property p_err_pair;
    pslverr |-> pready;
  endproperty
  a_err_pair: assert property (p_err_pair)
    else $error("pslverr without pready");
  property p_rd_idle;
    !pready |-> prdata == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("prdata not zero outside access");
  property p_upper_zero;
    pready |-> prdata[31:16] == 16'h0;
  endproperty
  a_upper_zero: assert property (p_upper_zero)
    else $error("upper read bits not zero");
  property p_align;
    pready && !pwrite && paddr >= `OFS_RESULT_BASE && paddr < 12'h040
      |-> prdata[15:12] == 4'h0 || prdata[3:0] == 4'h0;
  endproperty
  a_align: assert property (p_align)
    else $error("result word not aligned");
  property p_start_range;
    conv_start |-> conv_range != 2'h0;
  endproperty
  a_start_range: assert property (p_start_range)
    else $error("conversion with range zero");
  property p_start_pulse;
    conv_start |=> !conv_start;
  endproperty
  a_start_pulse: assert property (p_start_pulse)
    else $error("conv_start longer than one cycle");
  // Enables written at the access edge, irq registered one edge later
  property p_irq_mask;
    pready && pwrite && paddr == `OFS_ENABLES && pwdata[15:0] == 16'h0 |-> ##[1:2] !irq;
  endproperty
  a_irq_mask: assert property (p_irq_mask)
    else $error("irq high with all enables zero");
  c_conv: cover property (conv_start);
  c_err: cover property (pslverr);
  c_irq: cover property ($rose(irq));
endmodule // adc_ctrl_properties

// ### testbench/conv_core_model.sv
// Behavioural converter core answering each conv_start with one value.
// Assumes the control block pulses conv_start only while the core is idle.
`timescale 1ns/1ps
module conv_core_model (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // Control side
  input wire logic        conv_start,
  input wire logic [2:0]  conv_input,
  output logic            conv_done,
  output logic [11:0]     conv_value
);
  logic [2:0] cnt_r, in_r;
  logic       busy_r, slow_r;
  // Value carries the input number, so a wrong slot shows on readback
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      {cnt_r, in_r, busy_r, slow_r, conv_done} <= '0;
      conv_value <= 12'h000;
    end
    else
    begin
      conv_done  <= 1'b0;
      conv_value <= ~conv_value;
      if (conv_start)
      begin
        {busy_r, in_r} <= {1'b1, conv_input};
        cnt_r  <= slow_r ? 3'h6 : 3'h1;
        slow_r <= ~slow_r;
      end
      else if (busy_r && cnt_r == 3'h0)
      begin
        conv_done  <= 1'b1;
        conv_value <= {1'b1, in_r, 8'h5A};
        busy_r     <= 1'b0;
      end
      else if (busy_r)
        cnt_r <= cnt_r - 3'h1;
    end
  end
endmodule // conv_core_model

// ### testbench/tb_top.sv
// Bench for the converter control block: APB tasks and a call sequence.
// Assumes the core model on the converter side and the bound checker.
`timescale 1ns/1ps
`include "adc_ctrl_defs.svh"
module tb_top;
  import adc_ctrl_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic        pready, pslverr, rerr, irq, conv_start, conv_done;
  logic        tmr_uf = 0, pin_n = 1;
  logic [2:0]  conv_input;
  logic [1:0]  conv_range;
  logic [11:0] conv_value;
  int          fail_count = 0, tests_run = 0, n0, n1, c;
  always #12.5 pclk = ~pclk;
  adc_trigger_result_control u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .timer_underflow(tmr_uf),
    .external_trigger_pin_n(pin_n), .conv_start, .conv_input, .conv_range, .conv_done,
    .conv_value, .irq);
  conv_core_model u_core (.pclk, .presetn, .conv_start, .conv_input, .conv_done, .conv_value);
  task close_out;
    if (fail_count == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    {rdat, rerr} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
    if (pready !== 1'b1)
    begin
      fail_count++;
      close_out();
    end
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(rdat, e);
  endtask
  // Polling bounded; a miss shows as a mismatch
  task wait_flags(input logic [31:0] e);
    int i;
    i = 0;
    do
    begin
      apb(1'b0, `OFS_FLAGS, 32'h0);
      i++;
    end while (rdat !== e && i < 100);
    check(rdat, e);
  endtask
  task wait_start(output int n);
    n = 0;
    while (conv_start !== 1'b1 && n < 500)
    begin
      @(posedge pclk);
      n++;
    end
    if (n >= 500)
    begin
      fail_count++;
      close_out();
    end
  endtask
  function automatic logic [31:0] res(input int m);
    return {20'h0_0000, 1'b1, 3'(m), 8'h5A};
  endfunction
  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd(`OFS_TRIGGER, 32'h0000_0007);
    rd(`OFS_FLAGS, 32'h0);
    rd(`OFS_RESULT_BASE, 32'h0);
    wr(`OFS_RANGE, 32'h0000_FFFF);
    rd(`OFS_RANGE, 32'h0000_0003);
    apb(1'b0, 12'h0FC, 32'h0);
    check({31'h0, rerr}, 32'h1);
    wr(`OFS_RANGE, 32'h0);
    wr(`OFS_TRIGGER, 32'h0000_2200);
    wr(`OFS_CONTROL, 32'h2);
    repeat (200) @(posedge pclk);
    rd(`OFS_FLAGS, 32'h0);
    wr(`OFS_CONTROL, 32'h0);
    rd(`OFS_CONTROL, 32'h0);
    wr(`OFS_RANGE, 32'h1);
    wr(`OFS_ENABLES, 32'h0000_001C);
    rd(`OFS_ENABLES, 32'h0000_001C);
    wr(`OFS_CONTROL, 32'h2);
    wait_flags(32'h0000_001C);
    check({31'h0, irq}, 32'h1);
    for (int m = 1; m < 6; m++)
      rd(`OFS_RESULT_BASE + 12'(4 * m), (m > 1 && m < 5) ? res(m) : 32'h0);
    wr(`OFS_TRIGGER, 32'h0000_2280);
    for (int m = 2; m < 5; m++)
      rd(`OFS_RESULT_BASE + 12'(4 * m), res(m) << 4);
    wr(`OFS_CONTROL, 32'h0);
    repeat (8) @(posedge pclk);
    wr(`OFS_CONTROL, 32'h2);
    wait_flags(32'h0000_1C1C);
    wr(`OFS_ENABLES, 32'h0);
    repeat (2) @(posedge pclk);
    check({31'h0, irq}, 32'h0);
    wr(`OFS_FLAGS, 32'h0000_001C);
    rd(`OFS_FLAGS, 32'h0000_1C00);
    // Sampling time from code 0 and 7; tick phase adds up to three pclk
    for (int k = 0; k < 8; k += 7)
    begin
      wr(`OFS_CONTROL, 32'h0);
      wr(`OFS_TRIGGER, 32'h0000_0900 | k);
      wr(`OFS_CONTROL, 32'h2);
      wait_start(n1);
      if (k == 0)
        n0 = n1;
      repeat (20) @(posedge pclk);
    end
    check(32'((n1 - n0) >= 25 && (n1 - n0) <= 31), 32'h1);
    // Reserved code gets both sources at once
    for (c = 1; c < 4; c++)
    begin
      wr(`OFS_CONTROL, 32'h0);
      wr(`OFS_FLAGS, 32'h0000_FFFF);
      wr(`OFS_TRIGGER, 32'h0000_2D00 | (c << 4));
      wr(`OFS_CONTROL, 32'h2);
      repeat (100) @(posedge pclk);
      rd(`OFS_FLAGS, 32'h0);
      tmr_uf <= (c != 3);
      pin_n  <= (c == 1);
      @(posedge pclk);
      {tmr_uf, pin_n} <= 2'b01;
      repeat (100) @(posedge pclk);
      wait_flags(c == 2 ? 32'h0 : 32'h0000_0020);
    end
    wr(`OFS_CONTROL, 32'h0);
    wr(`OFS_FLAGS, 32'h0000_FFFF);
    wr(`OFS_TRIGGER, 32'h0000_3640);
    wr(`OFS_CONTROL, 32'h2);
    wait_flags(32'h0000_4040);
    wr(`OFS_CONTROL, 32'h0);
    close_out();
  end
endmodule // tb_top
bind adc_trigger_result_control adc_ctrl_properties u_props (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .conv_start,
  .conv_range, .irq);
